// ===== src/rpit_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rpit_defs.svh"
// Behaviour
// - One selected slow clock feeds both the counter and interval timer.
// - Counter runs while its enable is one, stops when zero.
// - Interval timer runs while its enable is one, stops when zero.
// - Shared prescaler stops when both functions off, counts otherwise.
// - First interval and counter tick fall anywhere within one period.
// - After first interrupt, interval output toggles every half interval.
// - Sixteen-cycle setting follows prescaler bit 3; settings 1 to 14 map likewise, 0 and 15 stay off.
// - Trim enable makes the prescaler correct by the trim value.
// - Correction adds or removes cycles spread over each million cycles.
// - Corrected timing shows in interval lengths, and in counter value except skips at prescaler setting 0.
// - Clearing trim enable lets a running correction slot finish.
// - Wrap and compare events match flag conditions, one slow period long.
// - Level taps give prescaled clock divided by 64 through 8192.
// - Compare and wrap flag on count after match; wrap clears counter.
// - Interval irq every 4 to 32768 cycles; taps 64 to 8192.
// - Busy flags for compare, top, count, control A, interval control.
module rpit_top (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Register port.
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Candidate slow clock pins.
  input  wire logic [3:0]  slow_clk_pin,
  // Event outputs.
  output logic             wrap_event,
  output logic             compare_event,
  output logic             interval_out,
  output logic      [7:0]  interval_event_taps,
  // Interrupt request lines.
  output logic             irq_counter,
  output logic             irq_interval
);

  ////////////////////////////////////////////////////////////////////////////
  // Slow clock capture.

  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  logic       sel_last_q;
  logic [1:0] source_select_q;
  logic       sel_level;
  logic       slow_tick;

  // Two flops per pin before anything looks at the level.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_meta_q <= 4'h0;
      pin_sync_q <= 4'h0;
      sel_last_q <= 1'b0;
    end else begin
      pin_meta_q <= slow_clk_pin;
      pin_sync_q <= pin_meta_q;
      sel_last_q <= sel_level;
    end
  end

  // One selected source gives one tick per rising slow edge to both functions.
  // Edges are only seen if the bus clock is at least twice as fast.
  assign sel_level = pin_sync_q[source_select_q];
  assign slow_tick = sel_level & ~sel_last_q;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  logic hit_ctrla;
  logic hit_status;
  logic hit_irqen;
  logic hit_irqflag;
  logic hit_trim;
  logic hit_src;
  logic hit_count;
  logic hit_top;
  logic hit_cmp;
  logic hit_pctrl;
  logic hit_pstatus;
  logic hit_pirqen;
  logic hit_pirqflag;

  // Each register owns exactly one address; all others read as zero.
  assign hit_ctrla    = reg_addr == `RPIT_OFF_CTRLA;
  assign hit_status   = reg_addr == `RPIT_OFF_STATUS;
  assign hit_irqen    = reg_addr == `RPIT_OFF_IRQEN;
  assign hit_irqflag  = reg_addr == `RPIT_OFF_IRQFLAG;
  assign hit_trim     = reg_addr == `RPIT_OFF_TRIM;
  assign hit_src      = reg_addr == `RPIT_OFF_SRC;
  assign hit_count    = reg_addr == `RPIT_OFF_COUNT;
  assign hit_top      = reg_addr == `RPIT_OFF_TOP;
  assign hit_cmp      = reg_addr == `RPIT_OFF_CMP;
  assign hit_pctrl    = reg_addr == `RPIT_OFF_PCTRL;
  assign hit_pstatus  = reg_addr == `RPIT_OFF_PSTATUS;
  assign hit_pirqen   = reg_addr == `RPIT_OFF_PIRQEN;
  assign hit_pirqflag = reg_addr == `RPIT_OFF_PIRQFLAG;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised registers.

  logic [7:0]           ctrla_sh_q;
  logic [7:0]           ctrla_q;
  rpit_pkg::rpit_word_t cnt_sh_q;
  rpit_pkg::rpit_word_t top_sh_q;
  rpit_pkg::rpit_word_t top_q;
  rpit_pkg::rpit_word_t cmp_sh_q;
  rpit_pkg::rpit_word_t cmp_q;
  logic [7:0]           pctrl_sh_q;
  logic [7:0]           pctrl_q;
  logic [4:0]           busy_q;
  logic [4:0]           wr_sync;
  logic [4:0]           apply;

  // Bit order: control A, count, top, compare, interval control.
  assign wr_sync = {hit_pctrl, hit_cmp, hit_top, hit_count, hit_ctrla} & {5{reg_wr}};
  // A pending copy moves on a slow edge; a fresh write that cycle waits.
  assign apply   = {5{slow_tick}} & busy_q & ~wr_sync;

  // Busy sets on the write and clears when the copy lands.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busy_q <= 5'h00;
    end else begin
      busy_q <= (busy_q & ~apply) | wr_sync;
    end
  end

  // Software-side copies take the bus write at once.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrla_sh_q <= `RPIT_RST_BYTE;
      cnt_sh_q   <= `RPIT_RST_WORD;
      top_sh_q   <= `RPIT_RST_TOP;
      cmp_sh_q   <= `RPIT_RST_WORD;
      pctrl_sh_q <= `RPIT_RST_BYTE;
    end else begin
      if (wr_sync[0]) ctrla_sh_q <= reg_wdata[7:0];
      if (wr_sync[1]) cnt_sh_q <= reg_wdata;
      if (wr_sync[2]) top_sh_q <= reg_wdata;
      if (wr_sync[3]) cmp_sh_q <= reg_wdata;
      if (wr_sync[4]) pctrl_sh_q <= reg_wdata[7:0];
    end
  end

  // Working copies change only on a slow edge, so the timers see clean values.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrla_q <= `RPIT_RST_BYTE;
      top_q   <= `RPIT_RST_TOP;
      cmp_q   <= `RPIT_RST_WORD;
      pctrl_q <= `RPIT_RST_BYTE;
    end else begin
      if (apply[0]) ctrla_q <= ctrla_sh_q;
      if (apply[2]) top_q <= top_sh_q;
      if (apply[3]) cmp_q <= cmp_sh_q;
      if (apply[4]) pctrl_q <= pctrl_sh_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain registers.

  logic [1:0] irq_enable_q;
  logic       interval_irq_enable_q;
  logic [7:0] crystal_trim_q;

  // Interrupt enables, trim and source take effect without a handshake.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_enable_q          <= 2'h0;
      interval_irq_enable_q <= 1'b0;
      crystal_trim_q        <= `RPIT_RST_BYTE;
      source_select_q       <= 2'h0;
    end else begin
      if (reg_wr && hit_irqen) irq_enable_q <= reg_wdata[1:0];
      if (reg_wr && hit_pirqen) interval_irq_enable_q <= reg_wdata[0];
      if (reg_wr && hit_trim) crystal_trim_q <= reg_wdata[7:0];
      if (reg_wr && hit_src) source_select_q <= reg_wdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared prescaler.

  rpit_tick_if tk ();

  logic counter_enable;
  logic interval_timer_enable;

  assign counter_enable        = ctrla_q[`RPIT_CTRLA_EN];
  assign interval_timer_enable = pctrl_q[`RPIT_PCTRL_EN];

  // Either function keeps the prescaler counting; both off holds it.
  assign tk.slow_tick = slow_tick;
  assign tk.run       = counter_enable | interval_timer_enable;
  assign tk.trim_en   = ctrla_q[`RPIT_CTRLA_TRIM];
  assign tk.trim_neg  = crystal_trim_q[`RPIT_TRIM_SIGN];
  assign tk.trim_mag  = crystal_trim_q[6:0];

  rpit_prescaler u_presc (
    .ref_clk (ref_clk),
    .reset   (reset),
    .tk      (tk.presc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counter.

  rpit_pkg::rpit_word_t tick_count_q;
  logic [3:0]           prescale;
  logic                 count_tick;
  logic                 at_top;
  logic                 at_cmp;
  logic                 wrap_hit;
  logic                 cmp_hit;

  // A tick is a change in the prescaler bit the setting selects, or any bit above it, so the
  // phase at enable decides when the first tick lands.
  assign prescale   = ctrla_q[`RPIT_CTRLA_PRE_LSB +: 4];
  assign count_tick = counter_enable & tk.stepped & (|(tk.flip >> prescale));
  assign at_top     = tick_count_q == top_q;
  assign at_cmp     = tick_count_q == cmp_q;
  assign wrap_hit   = count_tick & at_top;
  assign cmp_hit    = count_tick & at_cmp;

  // A synchronised count write wins over counting.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tick_count_q <= `RPIT_RST_WORD;
    end else if (apply[1]) begin
      tick_count_q <= cnt_sh_q;
    end else if (count_tick) begin
      tick_count_q <= at_top ? `RPIT_RST_WORD : tick_count_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events and flags.

  logic wrap_flag_q;
  logic cmp_flag_q;
  logic pit_flag_q;
  logic pit_rise;

  // Pulses start with the flag condition and end at the next slow edge.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wrap_event    <= 1'b0;
      compare_event <= 1'b0;
    end else begin
      wrap_event    <= wrap_hit | (wrap_event & ~slow_tick);
      compare_event <= cmp_hit | (compare_event & ~slow_tick);
    end
  end

  // Write one to clear; an event in the same cycle keeps the flag set.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wrap_flag_q <= 1'b0;
      cmp_flag_q  <= 1'b0;
      pit_flag_q  <= 1'b0;
    end else begin
      wrap_flag_q <= wrap_hit |
                     (wrap_flag_q & ~(reg_wr & hit_irqflag & reg_wdata[`RPIT_IRQ_WRAP]));
      cmp_flag_q  <= cmp_hit |
                     (cmp_flag_q & ~(reg_wr & hit_irqflag & reg_wdata[`RPIT_IRQ_CMP]));
      pit_flag_q  <= pit_rise | (pit_flag_q & ~(reg_wr & hit_pirqflag & reg_wdata[0]));
    end
  end

  // Requests stand while an enabled flag is set.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_counter  <= 1'b0;
      irq_interval <= 1'b0;
    end else begin
      irq_counter  <= |({cmp_flag_q, wrap_flag_q} & irq_enable_q);
      irq_interval <= pit_flag_q & interval_irq_enable_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interval timer.

  rpit_interval u_interval (
    .ref_clk (ref_clk),
    .reset   (reset),
    .tk      (tk.tap),
    .enable  (interval_timer_enable),
    .period  (pctrl_q[`RPIT_PCTRL_PER_LSB +: 4]),
    .level_q (interval_out),
    .rise_q  (pit_rise),
    .taps_q  (interval_event_taps)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read path.

  rpit_pkg::rpit_word_t rd_val;

  // Control reads show the software copy; count shows the live counter.
  assign rd_val = hit_ctrla    ? {8'h00, ctrla_sh_q} :
                  hit_status   ? {12'h000, busy_q[3:0]} :
                  hit_irqen    ? {14'h0000, irq_enable_q} :
                  hit_irqflag  ? {14'h0000, cmp_flag_q, wrap_flag_q} :
                  hit_trim     ? {8'h00, crystal_trim_q} :
                  hit_src      ? {14'h0000, source_select_q} :
                  hit_count    ? tick_count_q :
                  hit_top      ? top_sh_q :
                  hit_cmp      ? cmp_sh_q :
                  hit_pctrl    ? {8'h00, pctrl_sh_q} :
                  hit_pstatus  ? {15'h0000, busy_q[4]} :
                  hit_pirqen   ? {15'h0000, interval_irq_enable_q} :
                  hit_pirqflag ? {15'h0000, pit_flag_q} :
                  16'h0000;

  // Data stand for the one cycle after the strobe and are zero otherwise.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= `RPIT_RST_WORD;
    end else begin
      reg_rdata <= reg_rd ? rd_val : `RPIT_RST_WORD;
    end
  end

endmodule
`default_nettype wire

// ===== src/rpit_defs.svh
`ifndef RPIT_DEFS_SVH
`define RPIT_DEFS_SVH

// Register offsets on the plain register port.
`define RPIT_OFF_CTRLA     5'h00
`define RPIT_OFF_STATUS    5'h01
`define RPIT_OFF_IRQEN     5'h02
`define RPIT_OFF_IRQFLAG   5'h03
`define RPIT_OFF_TRIM      5'h06
`define RPIT_OFF_SRC       5'h07
`define RPIT_OFF_COUNT     5'h08
`define RPIT_OFF_TOP       5'h0A
`define RPIT_OFF_CMP       5'h0C
`define RPIT_OFF_PCTRL     5'h10
`define RPIT_OFF_PSTATUS   5'h11
`define RPIT_OFF_PIRQEN    5'h12
`define RPIT_OFF_PIRQFLAG  5'h13

// Field positions.
`define RPIT_CTRLA_EN      0
`define RPIT_CTRLA_TRIM    2
`define RPIT_CTRLA_PRE_LSB 3
`define RPIT_IRQ_WRAP      0
`define RPIT_IRQ_CMP       1
`define RPIT_PCTRL_EN      0
`define RPIT_PCTRL_PER_LSB 3
`define RPIT_TRIM_SIGN     7

// Reset values.
`define RPIT_RST_BYTE      8'h00
`define RPIT_RST_WORD      16'h0000
`define RPIT_RST_TOP       16'hFFFF

// Trim window of one million slow cycles, and the event tap range.
`define RPIT_TRIM_WINDOW   20'hF_4240
`define RPIT_TAP_LSB       5
`define RPIT_TAP_N         8

`endif

// ===== src/rpit_pkg.sv
`default_nettype none
package rpit_pkg;
  // States of the crystal trim sequencer.
  typedef enum logic [1:0] {
    TRIM_IDLE = 2'b01,
    TRIM_HOLD = 2'b10
  } rpit_trim_t;
  typedef logic [15:0] rpit_word_t;
endpackage
`default_nettype wire

// ===== src/rpit_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rpit_tick_if;
  logic                slow_tick;
  logic                run;
  logic                trim_en;
  logic                trim_neg;
  logic [6:0]          trim_mag;
  logic                stepped;
  rpit_pkg::rpit_word_t flip;
  rpit_pkg::rpit_word_t pre;

  modport ctl (output slow_tick, run, trim_en, trim_neg, trim_mag, input stepped, flip, pre);
  modport presc (input slow_tick, run, trim_en, trim_neg, trim_mag, output stepped, flip, pre);
  modport tap (input pre);
endinterface
`default_nettype wire

// ===== src/rpit_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "rpit_defs.svh"
module rpit_prescaler (
  // Shared prescaler link.
  input  wire logic  ref_clk,
  input  wire logic  reset,
  rpit_tick_if.presc tk
);
  rpit_pkg::rpit_trim_t state_q;
  logic [19:0]          acc_q;
  rpit_pkg::rpit_word_t step;
  rpit_pkg::rpit_word_t pre_d;
  logic [19:0]          acc_sum;
  logic                 fire;
  logic                 advance;

  // A correction slot either stalls one slow cycle or skips one count.
  assign advance = tk.slow_tick & tk.run;
  assign acc_sum = acc_q + {13'h0000, tk.trim_mag};
  assign fire    = tk.trim_en & (acc_sum >= `RPIT_TRIM_WINDOW);
  assign step    = (state_q == rpit_pkg::TRIM_HOLD) ?
                   (tk.trim_neg ? 16'h0002 : 16'h0000) : 16'h0001;
  assign pre_d   = tk.pre + step;

  // Counter, spreading accumulator and correction sequencer.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tk.pre     <= `RPIT_RST_WORD;
      tk.flip    <= `RPIT_RST_WORD;
      tk.stepped <= 1'b0;
      acc_q      <= 20'h0_0000;
      state_q    <= rpit_pkg::TRIM_IDLE;
    end else begin
      tk.stepped <= advance;
      tk.flip    <= advance ? (pre_d ^ tk.pre) : `RPIT_RST_WORD;
      if (advance) begin
        tk.pre <= pre_d;
        acc_q  <= fire ? (acc_sum - `RPIT_TRIM_WINDOW) : (tk.trim_en ? acc_sum : 20'h0_0000);
        case (state_q)
          rpit_pkg::TRIM_IDLE: state_q <= fire ? rpit_pkg::TRIM_HOLD : rpit_pkg::TRIM_IDLE;
          rpit_pkg::TRIM_HOLD: state_q <= rpit_pkg::TRIM_IDLE;
          default:             state_q <= rpit_pkg::TRIM_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== src/rpit_interval.sv
`timescale 1ns/1ps
`default_nettype none
`include "rpit_defs.svh"
module rpit_interval (
  // Clock and reset.
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  // Prescaler view and setup.
  rpit_tick_if.tap                    tk,
  input  wire logic                   enable,
  input  wire logic [3:0]             period,
  // Interval outputs.
  output logic                        level_q,
  output logic                        rise_q,
  output logic [`RPIT_TAP_N-1:0]      taps_q
);
  logic sel;

  // Setting k from 1 to 14 follows prescaler bit k, so the period is 2^(k+1) slow cycles; 0 and 15 stay low.
  assign sel = (period != 4'h0) && (period != 4'hF) && tk.pre[period];

  // Square output and its rising edge, which marks each interval.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      level_q <= 1'b0;
      rise_q  <= 1'b0;
    end else begin
      level_q <= enable & sel;
      rise_q  <= enable & sel & ~level_q;
    end
  end

  // Level taps at divide-by-64 up to divide-by-8192.
  genvar i;
  generate
    for (i = 0; i < `RPIT_TAP_N; i++) begin : g_tap
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          taps_q[i] <= 1'b0;
        end else begin
          taps_q[i] <= enable & tk.pre[`RPIT_TAP_LSB+i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== verification/rpit_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "rpit_defs.svh"
module rpit_checker (
  // Clock and reset.
  input wire logic        ref_clk,
  input wire logic        reset,
  // Register port.
  input wire logic [4:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Slow clock pins.
  input wire logic [3:0]  slow_clk_pin,
  // Events and requests.
  input wire logic        wrap_event,
  input wire logic        compare_event,
  input wire logic        interval_out,
  input wire logic [7:0]  interval_event_taps,
  input wire logic        irq_counter,
  input wire logic        irq_interval
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  logic cnt_irq_wr;
  logic pit_irq_wr;
  // A request may only drop after software touched its flag or enable register.
  assign cnt_irq_wr = reg_wr && (reg_addr == `RPIT_OFF_IRQFLAG || reg_addr == `RPIT_OFF_IRQEN);
  assign pit_irq_wr = reg_wr && (reg_addr == `RPIT_OFF_PIRQFLAG || reg_addr == `RPIT_OFF_PIRQEN);

  ////////////////////////////////////////////////////////////////////////////////
  // Interval and tap checks use falls, not rises, because the first high phase after enable may be short.
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> (!wrap_event && !compare_event
    && !interval_out && interval_event_taps == 8'h00 && !irq_counter && !irq_interval))
    else $error("output active after reset");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  a_wrap_pulse_len: assert property ($rose(wrap_event) |-> wrap_event [*3] ##[1:1000] !wrap_event)
    else $error("wrap pulse length wrong");
  a_cmp_pulse_len: assert property ($rose(compare_event) |-> compare_event [*3] ##[1:1000]
    !compare_event) else $error("compare pulse length wrong");
  a_cnt_irq_hold: assert property ($fell(irq_counter) |-> $past(cnt_irq_wr) || $past(cnt_irq_wr, 2))
    else $error("counter request dropped on its own");
  a_pit_irq_hold: assert property ($fell(irq_interval) |-> $past(pit_irq_wr) || $past(pit_irq_wr, 2))
    else $error("interval request dropped on its own");
  a_pit_half_low: assert property ($fell(interval_out) |-> !interval_out [*7])
    else $error("interval low half too short");
  a_tap_half_low: assert property ($fell(interval_event_taps[0]) |-> !interval_event_taps[0] [*8])
    else $error("tap low half too short");

  // Main scenarios.
  c_wrap: cover property ($rose(wrap_event));
  c_cmp: cover property ($rose(compare_event));
  c_pit: cover property ($fell(interval_out));
  c_clear: cover property ($fell(irq_counter));
endmodule

bind rpit_top rpit_checker i_rpit_checker (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .slow_clk_pin(slow_clk_pin), .wrap_event(wrap_event), .compare_event(compare_event),
  .interval_out(interval_out), .interval_event_taps(interval_event_taps),
  .irq_counter(irq_counter), .irq_interval(irq_interval));
`default_nettype wire

// ===== verification/rpit_evsys_model.sv
`timescale 1ns/1ps
`default_nettype none
module rpit_evsys_model (
  // Clock and reset.
  input wire logic       ref_clk,
  input wire logic       reset,
  // Event lines taken in by the event users.
  input wire logic       wrap_event,
  input wire logic       compare_event,
  input wire logic       interval_out,
  input wire logic [7:0] interval_event_taps
);
  int unsigned cyc;
  int unsigned rises [4];
  int unsigned stamp [4];
  int unsigned gap   [4];
  int unsigned high  [4];
  logic [3:0]  prev;
  logic [3:0]  now;

  // Channels: 0 wrap, 1 compare, 2 interval level, 3 slowest-but-seven tap.
  assign now = {interval_event_taps[0], interval_out, compare_event, wrap_event};

  // Event users see levels only at bus clock edges, so gaps are in bus cycles.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    prev <= reset ? 4'h0 : now;
    for (int i = 0; i < 4; i++) begin
      if (now[i] && !prev[i]) begin
        rises[i] <= rises[i] + 1;
        gap[i] <= cyc - stamp[i];
        stamp[i] <= cyc;
      end
      if (!now[i] && prev[i]) begin
        high[i] <= cyc - stamp[i];
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/rpit_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rpit_defs.svh"
module rpit_top_tb;
  logic        ref_clk      = 1'b0;
  logic        reset        = 1'b1;
  logic [4:0]  reg_addr     = 5'h00;
  logic [15:0] reg_wdata    = 16'h0000;
  logic        reg_wr       = 1'b0;
  logic        reg_rd       = 1'b0;
  logic [3:0]  slow_clk_pin = 4'h0;
  logic [15:0] reg_rdata;
  logic        wrap_event;
  logic        compare_event;
  logic        interval_out;
  logic [7:0]  interval_event_taps;
  logic        irq_counter;
  logic        irq_interval;
  logic [15:0] rd_q;
  logic [15:0] cnt_q;
  int unsigned mismatches   = 0;
  int unsigned total_checks = 0;
  int unsigned cycles       = 0;
  int unsigned t, c, p, k, r;
  localparam logic [4:0] ZERO_REGS [12] = '{`RPIT_OFF_CTRLA, `RPIT_OFF_STATUS, `RPIT_OFF_IRQEN,
    `RPIT_OFF_IRQFLAG, `RPIT_OFF_TRIM, `RPIT_OFF_SRC, `RPIT_OFF_COUNT, `RPIT_OFF_CMP,
    `RPIT_OFF_PCTRL, `RPIT_OFF_PSTATUS, `RPIT_OFF_PIRQEN, `RPIT_OFF_PIRQFLAG};

  rpit_top i_rpit_top (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .slow_clk_pin(slow_clk_pin), .wrap_event(wrap_event), .compare_event(compare_event),
    .interval_out(interval_out), .interval_event_taps(interval_event_taps),
    .irq_counter(irq_counter), .irq_interval(irq_interval));
  rpit_evsys_model i_rpit_evsys_model (.ref_clk(ref_clk), .reset(reset),
    .wrap_event(wrap_event), .compare_event(compare_event), .interval_out(interval_out),
    .interval_event_taps(interval_event_taps));

  ////////////////////////////////////////////////////////////////////////////////
  // Bus clock, and slow oscillators of 8, 12 and 16 bus cycles; pin 3 models one never started.
  // Slow edges sit half a bus cycle from the sampling edge, so measured gaps are exact.
  always #50 ref_clk = ~ref_clk;
  always #400 slow_clk_pin[0] = ~slow_clk_pin[0];
  always #600 slow_clk_pin[1] = ~slow_clk_pin[1];
  always #800 slow_clk_pin[2] = ~slow_clk_pin[2];

  // Hang guard sized well above the longest scenario.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches = mismatches + 1;
      $display("[ERR] %0t run did not finish", $time);
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Single-cycle strobes, released at the edge that took them.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    rd_q = reg_rdata;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp, input string what);
    rd(a);
    check(rd_q, exp, what);
  endtask

  // Software habit: wait for both busy registers to clear before the next write.
  task automatic settle();
    logic [15:0] s;
    s = 16'hFFFF;
    for (int i = 0; i < 100 && s !== 16'h0000; i++) begin
      rd(`RPIT_OFF_STATUS);
      s = rd_q;
      rd(`RPIT_OFF_PSTATUS);
      s = s | rd_q;
    end
    check(s, 16'h0000, "busy stuck");
  endtask

  task automatic wait_rises(input int idx, input int unsigned n);
    int unsigned base;
    base = i_rpit_evsys_model.rises[idx];
    for (int i = 0; i < 20000 && i_rpit_evsys_model.rises[idx] < base + n; i++) begin
      @(posedge ref_clk);
    end
    @(negedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(75375));
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    rd_chk(`RPIT_OFF_TOP, `RPIT_RST_TOP, "top reset");
    foreach (ZERO_REGS[i]) rd_chk(ZERO_REGS[i], `RPIT_RST_WORD, "reset value");
    wr(5'h0E, 16'h1234);
    rd_chk(5'h0E, 16'h0000, "unmapped");
    wr(`RPIT_OFF_TRIM, 16'h0085);
    rd_chk(`RPIT_OFF_TRIM, 16'h0085, "trim field");
    $display("test reset and map done");

    // A dead source keeps the handshake pending; a live one completes it.
    wr(`RPIT_OFF_SRC, 16'h0003);
    wr(`RPIT_OFF_CMP, 16'h0055);
    rd_chk(`RPIT_OFF_STATUS, 16'h0008, "compare busy");
    rd_chk(`RPIT_OFF_CMP, 16'h0055, "compare copy");
    wr(`RPIT_OFF_SRC, 16'h0000);
    settle();
    $display("test handshake done");

    // Counter with random top, compare and prescaler.
    t = 2 + $urandom % 4;
    c = $urandom % t;
    p = $urandom % 3;
    wr(`RPIT_OFF_CMP, 16'(c));
    settle();
    wr(`RPIT_OFF_TOP, 16'(t));
    settle();
    wr(`RPIT_OFF_IRQEN, 16'h0003);
    wr(`RPIT_OFF_CTRLA, 16'(p << `RPIT_CTRLA_PRE_LSB));
    settle();
    wr(`RPIT_OFF_CTRLA, 16'((p << `RPIT_CTRLA_PRE_LSB) | 1));
    settle();
    wait_rises(0, 2);
    check(16'(i_rpit_evsys_model.gap[0]), 16'(((t + 1) * 8) << p), "wrap period");
    r = i_rpit_evsys_model.stamp[0] - i_rpit_evsys_model.stamp[1];
    check(16'(r), 16'(((t - c) * 8) << p), "compare to wrap");
    r = i_rpit_evsys_model.high[0];
    check(16'(r >= 5 && r <= 9), 16'h0001, "wrap pulse length");
    check(16'(irq_counter), 16'h0001, "counter request");
    rd_chk(`RPIT_OFF_IRQFLAG, 16'h0003, "counter flags");
    wr(`RPIT_OFF_CTRLA, 16'(p << `RPIT_CTRLA_PRE_LSB));
    settle();
    rd(`RPIT_OFF_COUNT);
    cnt_q = rd_q;
    repeat (200) @(posedge ref_clk);
    rd_chk(`RPIT_OFF_COUNT, cnt_q, "count held");
    wr(`RPIT_OFF_IRQFLAG, 16'h0003);
    rd_chk(`RPIT_OFF_IRQFLAG, 16'h0000, "flags cleared");
    check(16'(irq_counter), 16'h0000, "request cleared");
    $display("test counter done");

    // Interval timer from the other pin, shortest setting first, then random.
    wr(`RPIT_OFF_SRC, 16'h0001);
    wr(`RPIT_OFF_PIRQEN, 16'h0001);
    for (int n = 0; n < 2; n++) begin
      k = (n == 0) ? 1 : 1 + $urandom % 5;
      wr(`RPIT_OFF_PCTRL, 16'(k << `RPIT_PCTRL_PER_LSB));
      settle();
      wr(`RPIT_OFF_PCTRL, 16'((k << `RPIT_PCTRL_PER_LSB) | 1));
      settle();
      wait_rises(2, 3);
      check(16'(i_rpit_evsys_model.gap[2]), 16'(12 << (k + 1)), "interval period");
      check(16'(i_rpit_evsys_model.high[2]), 16'(12 << k), "interval half");
      check(16'(irq_interval), 16'h0001, "interval request");
      if (n == 0) begin
        wait_rises(3, 2);
        check(16'(i_rpit_evsys_model.gap[3]), 16'(64 * 12), "tap period");
      end
      wr(`RPIT_OFF_PIRQFLAG, 16'h0001);
      wr(`RPIT_OFF_PCTRL, 16'h0000);
      settle();
    end
    r = i_rpit_evsys_model.rises[2];
    repeat (300) @(posedge ref_clk);
    check(16'(i_rpit_evsys_model.rises[2] - r), 16'h0000, "interval stopped");
    check(16'(interval_out), 16'h0000, "interval low when off");
    check(16'(interval_event_taps), 16'h0000, "taps low when off");
    $display("test interval done");
    end_of_test();
  end
endmodule
`default_nettype wire
